// *** rtl/stc_defs.svh ***
`ifndef STC_DEFS_SVH
`define STC_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define STC_ADDR_W        2
`define STC_OFF_CTRL      2'h0
`define STC_OFF_DATA      2'h1

// ****************************************
// Control register fields
// ****************************************
`define STC_F_CLK_MASTER  7
`define STC_F_NINE_BIT    6
`define STC_F_TX_EN       5
`define STC_F_SYNC_MODE   4
`define STC_F_BREAK       3
`define STC_F_HIGH_SPEED  2
`define STC_F_SHIFT_EMPTY 1
`define STC_F_NINTH_BIT   0
`define STC_CTRL_RESET    8'h02
`define STC_CTRL_WMASK    8'hFD

// ****************************************
// Frame shapes and timing
// ****************************************
`define STC_SHIFT_W       14
`define STC_BITS_ASYNC8   4'hA
`define STC_BITS_ASYNC9   4'hB
`define STC_BITS_BREAK    4'hE
`define STC_BITS_SYNC8    4'h8
`define STC_BITS_SYNC9    4'h9
`define STC_LOW_SPEED_MUL 4

`endif

// *** rtl/stc_pkg.sv ***
package stc_pkg;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    STC_IDLE  = 2'b01,
    STC_SHIFT = 2'b10
  } stc_state_type;

  typedef struct packed {
    stc_state_type state;
    logic [7:0]    ctrl;
    logic [8:0]    hold;
    logic          hold_full;
    logic [13:0]   shift;
    logic [3:0]    bits;
    logic [15:0]   cnt;
    logic          ck_high;
    logic          ck_prev;
    logic          sync_run;
    logic          master_run;
    logic          brk_run;
    logic [7:0]    rdata;
  } stc_regs_type;

endpackage

// *** rtl/stc_transmit_control.sv ***
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ns
// Contract
// - nine-bit select picks nine- or eight-bit characters
// - high-speed select picks divisor, async only
// - shift-empty status reads one when shifter empty
// - lowest field is the ninth transmitted bit
// - sync mode: receive enables override transmit enable
`include "stc_defs.svh"

module stc_transmit_control #(
  parameter logic [15:0] DIV_HIGH = 16'h0004
) (
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic [1:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       SINGLE_RECEIVE_ENABLE,
  input  wire logic       CONTINUOUS_RECEIVE_ENABLE,
  input  wire logic       CK_I,
  output logic            CK_O,
  output logic            CK_OE,
  output logic            DT_O,
  output logic            DT_OE
);
  import stc_pkg::*;

  // ****************************************
  // Overview
  // ****************************************
  // Control register, one byte at offset zero:
  //   bit 7  clock source, master when set (sync only)
  //   bit 6  nine-bit characters
  //   bit 5  transmitter enable
  //   bit 4  mode select, sync when set
  //   bit 3  break request, cleared by hardware
  //   bit 2  high-speed divisor (async only)
  //   bit 1  shifter empty, read only, resets to one
  //   bit 0  ninth transmitted bit
  // Data port at offset one:
  //   A write fills the one-character holding buffer
  //   A write while the buffer is full is dropped
  //   A read returns the buffer-full flag in bit 0
  //   The ninth bit is latched with the data byte,
  //   so changing bit 0 later does not alter it
  // Async frame on the clock pin:
  //   start bit low, data LSB first, ninth bit for nine-bit characters, stop high
  //   one bit lasts DIV_HIGH cycles, or four times that
  //   when the high-speed divisor is off
  // Break frame:
  //   thirteen low bits, then a high stop bit
  //   the buffered byte is consumed and not sent
  //   break request clears only when a break frame ends,
  //   so a request made during a normal frame waits its turn
  // Sync master frame:
  //   clock low for DIV_HIGH cycles, then high for DIV_HIGH
  //   data moves as the clock falls, stable while high
  //   eight or nine bits, no start or stop
  // Sync slave frame:
  //   data moves one cycle after each falling clock edge
  //   the remote master must idle its clock low, or the
  //   first falling edge skips the first bit
  // Receive enables in sync mode drop the transmitter at
  // once; the character in flight is lost, not resumed.
  // Limitation: no receive path and no baud generator here,
  // the divisor is a fixed parameter.

  // ****************************************
  // State
  // ****************************************
  stc_regs_type q;
  stc_regs_type d;

  logic        tx_on;
  logic        sync_m;
  logic [15:0] bit_period;

  // Receive wins over transmit in sync mode
  assign sync_m = q.ctrl[`STC_F_SYNC_MODE];
  assign tx_on  = q.ctrl[`STC_F_TX_EN]
                  & ~(sync_m & (SINGLE_RECEIVE_ENABLE | CONTINUOUS_RECEIVE_ENABLE));

  // Speed select only matters for asynchronous framing
  assign bit_period = q.ctrl[`STC_F_HIGH_SPEED] ? DIV_HIGH
                      : 16'(DIV_HIGH * `STC_LOW_SPEED_MUL);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d         = q;
    d.rdata   = 8'h00;
    d.ck_prev = CK_I;

    unique case (q.state)
      STC_IDLE: begin
        d.ck_high = 1'b0;
        if (tx_on && q.hold_full) begin
          d.hold_full  = 1'b0;
          d.state      = STC_SHIFT;
          d.sync_run   = sync_m;
          d.master_run = q.ctrl[`STC_F_CLK_MASTER];
          d.brk_run    = 1'b0;
          if (sync_m) begin
            d.cnt   = DIV_HIGH - 16'h0001;
            d.shift = {5'h1F, q.hold};
            d.bits  = q.ctrl[`STC_F_NINE_BIT] ? `STC_BITS_SYNC9 : `STC_BITS_SYNC8;
          end else begin
            d.cnt = bit_period - 16'h0001;
            if (q.ctrl[`STC_F_BREAK]) begin
              // Start bit plus twelve zeros, then stop; data is discarded
              d.shift   = {1'b1, 13'h0000};
              d.brk_run = 1'b1;
              d.bits  = `STC_BITS_BREAK;
            end else if (q.ctrl[`STC_F_NINE_BIT]) begin
              d.shift = {4'hF, q.hold, 1'b0};
              d.bits  = `STC_BITS_ASYNC9;
            end else begin
              d.shift = {5'h1F, q.hold[7:0], 1'b0};
              d.bits  = `STC_BITS_ASYNC8;
            end
          end
        end
      end
      STC_SHIFT: begin
        if (!tx_on) begin
          // Disabling the transmitter aborts the character in flight
          d.state = STC_IDLE;
          d.shift = {`STC_SHIFT_W{1'b1}};
        end else if (q.sync_run && !q.master_run) begin
          // Slave: advance on each falling edge of the external clock
          if (q.ck_prev && !CK_I) begin
            d.shift = {1'b1, q.shift[13:1]};
            d.bits  = q.bits - 4'h1;
            if (q.bits == 4'h1) begin
              d.state = STC_IDLE;
            end
          end
        end else if (q.cnt != 16'h0000) begin
          d.cnt = q.cnt - 16'h0001;
        end else begin
          d.cnt = q.sync_run ? DIV_HIGH - 16'h0001 : bit_period - 16'h0001;
          if (q.sync_run) begin
            d.ck_high = ~q.ck_high;
          end
          // A bit ends at the count in async, after the high half in master
          if (!q.sync_run || q.ck_high) begin
            d.shift = {1'b1, q.shift[13:1]};
            d.bits  = q.bits - 4'h1;
            if (q.bits == 4'h1) begin
              d.state = STC_IDLE;
              // Only a break frame retires the request
              if (q.brk_run) begin
                d.ctrl[`STC_F_BREAK] = 1'b0;
              end
            end
          end
        end
      end
    endcase

    // Software writes after the hardware clear, so a new set wins
    if (WR && ADDR == `STC_OFF_CTRL) begin
      d.ctrl = (WDATA & `STC_CTRL_WMASK) | (d.ctrl & ~`STC_CTRL_WMASK);
    end
    if (WR && ADDR == `STC_OFF_DATA && !q.hold_full) begin
      d.hold      = {q.ctrl[`STC_F_NINTH_BIT], WDATA};
      d.hold_full = 1'b1;
    end

    d.ctrl[`STC_F_SHIFT_EMPTY] = (d.state == STC_IDLE);

    if (RD) begin
      unique case (ADDR)
        `STC_OFF_CTRL: d.rdata = q.ctrl;
        `STC_OFF_DATA: d.rdata = {7'h00, q.hold_full};
        default:       d.rdata = 8'h00;
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge CLK) begin
    if (RST) begin
      q.state      <= STC_IDLE;
      q.ctrl       <= `STC_CTRL_RESET;
      q.hold       <= 9'h000;
      q.hold_full  <= 1'b0;
      q.shift      <= {`STC_SHIFT_W{1'b1}};
      q.bits       <= 4'h0;
      q.cnt        <= 16'h0000;
      q.ck_high    <= 1'b0;
      q.ck_prev    <= 1'b0;
      q.sync_run   <= 1'b0;
      q.master_run <= 1'b0;
      q.brk_run    <= 1'b0;
      q.rdata      <= 8'h00;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Pins
  // ****************************************
  // Async uses the clock pin as the serial line; sync master drives the clock
  always_comb begin
    RDATA = q.rdata;
    if (!sync_m) begin
      CK_O  = q.shift[0];
      CK_OE = q.ctrl[`STC_F_TX_EN];
      DT_O  = 1'b1;
      DT_OE = 1'b0;
    end else begin
      CK_O  = q.ck_high;
      CK_OE = q.ctrl[`STC_F_CLK_MASTER];
      DT_O  = q.shift[0];
      DT_OE = tx_on;
    end
  end

endmodule

// *** test/stc_props.sv ***
`timescale 1ns/1ns
// ****************************************
// Port checks of the transmit control block
// ****************************************
module stc_props (
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic [1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       SINGLE_RECEIVE_ENABLE,
  input wire logic       CONTINUOUS_RECEIVE_ENABLE,
  input wire logic       CK_O,
  input wire logic       CK_OE,
  input wire logic       DT_O,
  input wire logic       DT_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence wr_ctrl; WR && ADDR == 2'h0; endsequence
  sequence rd_ctrl; RD && ADDR == 2'h0; endsequence
  // Read data only in the cycle after a read
  rd_quiet_a: assert property (!RD |=> RDATA == 8'h00) else $error("read data out of turn");
  rd_unmapped_a: assert property (RD && ADDR[1] |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  // Break and status bits move on their own, so they are masked out
  ctrl_echo_a: assert property (
    wr_ctrl ##2 rd_ctrl |=> (RDATA & 8'hF5) == ($past(WDATA, 3) & 8'hF5))
    else $error("control readback differs");
  pin_enable_a: assert property (
    rd_ctrl |=> CK_OE == (RDATA[4] ? RDATA[7] : RDATA[5])) else $error("clock pin enable wrong");
  async_pins_a: assert property (
    rd_ctrl ##1 !RDATA[4] |-> DT_O && !DT_OE) else $error("data pin active in async");
  rx_wins_a: assert property (
    (SINGLE_RECEIVE_ENABLE || CONTINUOUS_RECEIVE_ENABLE) [*2] |-> !DT_OE)
    else $error("transmit drives over receive");
  busy_flag_a: assert property (
    (RD && ADDR == 2'h0 && !CK_O) ##1 RDATA[5:4] == 2'b10 |-> !RDATA[1])
    else $error("empty while sending");
  reset_out_a: assert property (
    $fell(RST) |-> CK_O && !CK_OE && DT_O && !DT_OE && RDATA == 8'h00)
    else $error("outputs wrong after reset");
endmodule

bind stc_transmit_control stc_props props (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .SINGLE_RECEIVE_ENABLE(SINGLE_RECEIVE_ENABLE),
  .CONTINUOUS_RECEIVE_ENABLE(CONTINUOUS_RECEIVE_ENABLE), .CK_O(CK_O), .CK_OE(CK_OE),
  .DT_O(DT_O), .DT_OE(DT_OE));

// *** test/stc_remote_clock.sv ***
`timescale 1ns/1ns
// ****************************************
// Remote synchronous master
// ****************************************
module stc_remote_clock #(
  parameter int HALF = 6
) (
  input  wire logic clk,
  input  wire logic run,
  output logic      ck
);
  int cnt = 0;
  initial ck = 1'b0;
  // Clock runs only while run is high; idles low like the master clock
  always @(posedge clk) begin
    cnt <= (cnt + 1) % HALF;
    if (!run) ck <= 1'b0;
    else if (cnt == 0) ck <= ~ck;
  end
endmodule

// *** test/serial_transmit_control_bench.sv ***
`timescale 1ns/1ns
// ****************************************
// Bench
// ****************************************
module serial_transmit_control_bench;
  logic clk = 0, rst = 1, wr = 0, rd = 0, sre = 0, cre = 0, run = 0, rd_p = 0;
  logic [1:0] addr = 0;
  logic [7:0] wdata = 0, v;
  logic [13:0] bits;
  logic [15:0] e;
  logic [15:0] exp_q [$];
  wire logic [7:0] rdata;
  wire logic ck_i, ck_o, ck_oe, dt_o, dt_oe;
  int error_cnt = 0, checked = 0, seed = 46;
  logic sel = 0, tck, tck_p = 0;
  logic [7:0] sb = 0;
  int grab = 0;

  stc_transmit_control #(.DIV_HIGH(16'h0004)) dut (.CLK(clk), .RST(rst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SINGLE_RECEIVE_ENABLE(sre),
    .CONTINUOUS_RECEIVE_ENABLE(cre), .CK_I(ck_i), .CK_O(ck_o), .CK_OE(ck_oe), .DT_O(dt_o),
    .DT_OE(dt_oe));
  stc_remote_clock far (.clk(clk), .run(run), .ck(ck_i));

  initial forever #2 clk = ~clk;

  task automatic check(input string what, input logic [13:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("mismatches %0d in %0d checks", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // One access, then an idle edge so strobes never retoggle in one step
  task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d, m);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    if (!w) exp_q.push_back({m, d});
    @(posedge clk);
    wr <= 0;
    rd <= 0;
    @(posedge clk);
  endtask

  // Read results are judged half a cycle after they land
  always @(posedge clk) rd_p <= rd;
  always @(negedge clk) begin
    if (rd_p) begin
      e = exp_q.pop_front();
      check("read", {6'h0, rdata & e[15:8]}, {6'h0, e[7:0] & e[15:8]});
    end
  end

  // Gathers sync data LSB first on rising edges of the bit clock, grab bits at most
  always @(negedge clk) begin
    tck = sel ? ck_i : ck_o;
    if (grab > 0 && tck && !tck_p) begin
      sb = {dt_o, sb[7:1]};
      grab--;
    end
    tck_p = tck;
  end

  // Sends one character and samples the line at mid bit; status read while busy
  task automatic frame(input logic [7:0] c, d, input int n, bt);
    int k;
    bits = 0;
    bus(1, 0, c, 0);
    bus(1, 1, d, 0);
    for (k = 0; k < 300 && ck_o !== 1'b0; k++) @(posedge clk);
    if (k == 300) begin
      error_cnt++;
      close_out;
    end
    bus(0, 0, 8'h00, 8'h02);
    repeat (bt / 2 - 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = ck_o;
      repeat (bt) @(posedge clk);
    end
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    bus(0, 0, 8'h02, 8'hFF);
    bus(1, 2, 8'hFF, 0);
    bus(0, 2, 8'h00, 8'hFF);
    bus(0, 3, 8'h00, 8'hFF);
    // Random settings with transmit and break off, receive enables random too
    repeat (20) begin
      v = 8'($random(seed)) & 8'hD7;
      sre <= v[1];
      cre <= 1'($random(seed));
      bus(1, 0, v, 0);
      bus(0, 0, v | 8'h02, 8'hFF);
    end
    sre <= 0;
    cre <= 0;
    v = 8'($random(seed));
    frame(8'h24, v, 10, 4);
    check("line8", bits, {4'h0, 1'b1, v, 1'b0});
    frame(8'h61, ~v, 11, 16);
    check("line9", bits, {3'h0, 2'b11, ~v, 1'b0});
    frame(8'h2C, v, 14, 4);
    check("break", bits, {1'b1, 13'h0});
    repeat (4) @(posedge clk);
    bus(0, 0, 8'h26, 8'hFF);
    // Reception holds the line, then a master character, then a slave character on the remote clock
    sre <= 1;
    bus(1, 0, 8'hB0, 0);
    bus(1, 1, 8'hA5, 0);
    repeat (40) @(posedge clk);
    sel = 0;
    sb = 0;
    grab = 8;
    sre <= 0;
    repeat (80) @(posedge clk);
    check("sync_master", {6'h0, sb}, {6'h0, 8'hA5});
    sel = 1;
    sb = 0;
    grab = 8;
    bus(1, 0, 8'h30, 0);
    bus(1, 1, 8'h3C, 0);
    bus(0, 0, 8'h30, 8'hFF);
    run <= 1;
    repeat (300) @(posedge clk);
    run <= 0;
    check("sync_slave", {6'h0, sb}, {6'h0, 8'h3C});
    bus(0, 0, 8'h32, 8'hFF);
    close_out;
  end
endmodule
